// *** hdl/slp_map.svh ***
// mode codes and timing counts of the sleep controller
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH

// ---------------------------------------------------------------
// sleep mode codes
// ---------------------------------------------------------------
`define SLP_MODE_IDLE   3'h0
`define SLP_MODE_ADCNR  3'h1
`define SLP_MODE_PDOWN  3'h2
`define SLP_MODE_PSAVE  3'h3
`define SLP_MODE_STBY   3'h6
`define SLP_MODE_XSTBY  3'h7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SLP_CLK_MHZ        125
`define SLP_CNT_W          16
`define SLP_STBY_WAKE_CYC  6
`define SLP_FAST_WAKE_CYC  1
`define SLP_OSC_WAKE_CYC   16
`define SLP_VREF_START_NS  1000
`define SLP_VREF_CYC ((`SLP_VREF_START_NS*`SLP_CLK_MHZ+999)/1000)

`endif

// *** hdl/slp_pkg.sv ***
// types shared by the sleep controller
`default_nettype none
package slp_pkg;
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} slp_fsm_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic tmr_osc;
  } slp_clk_t;

  typedef struct packed {
    slp_fsm_t   fsm;
    logic [2:0] mode;
    slp_clk_t   clk;
    logic       adc_power;
    logic       acomp_power;
    logic       vref_power;
    logic       vref_ready;
    logic       bod_power;
    logic       wdt_run;
    logic       input_buf_en;
    logic       scan_if_en;
    logic       tdo_out;
    logic       tdo_oe;
    logic       adc_ext_conv;
    logic       adc_en_d;
    logic       sleeping;
  } slp_state_t;
endpackage
`default_nettype wire

// *** hdl/slp_cnt.sv ***
// loadable down counter used for wake-up and reference start-up delays
`timescale 1ns/1ps
`default_nettype none
module slp_cnt #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } slp_cnt_state_t;

  slp_cnt_state_t st;
  slp_cnt_state_t next_st;

  if (W < 2) begin : g_chk
    $error("slp_cnt: W must be at least 2");
  end

  // load wins, otherwise count down to zero and hold
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = load_val;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign done = (st.cnt == '0);
endmodule
`default_nettype wire

// *** hdl/slp_ctrl.sv ***
// sleep-mode clock gating and power controller
`timescale 1ns/1ps
`default_nettype none
`include "slp_map.svh"
// How it works
// - idle stops only cpu and flash clocks
// - adc noise mode runs adc, async, main
// - timer osc needs async select; async clock does in psave, xstby
// - standby modes keep main oscillator running with ext crystal
// - deep modes wake on level/ext_irq_two pins, twi match; psave, xstby also on async timer2
// - enabled adc stays powered in sleep
// - adc re-enable makes next conversion extended
// - comparator off in deep sleep modes
// - reference powered only when needed, start-up
// - brown-out detector stays on by fuse
// - enabled watchdog keeps running in sleep
// - debug fuse with scan port on keeps main osc in deep
// - tdo undriven unless tap is shifting
// - sleep request decodes mode select field
// - standby wake-up takes six cycles
module slp_ctrl #(
  parameter int OSC_WAKE_CYC = `SLP_OSC_WAKE_CYC,
  parameter int VREF_CYC     = `SLP_VREF_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic       sleep_req,
  input  wire logic [2:0] sleep_mode_select,
  input  wire logic       ext_crystal_sel,
  input  wire logic       timer2_async_select,
  input  wire logic       brownout_enable_fuse,
  input  wire logic       debug_enable_fuse,
  input  wire logic       scan_port_enable_fuse,
  input  wire logic       scan_port_disable,
  input  wire logic       adc_enable,
  input  wire logic       adc_conv_start,
  input  wire logic       acomp_enable,
  input  wire logic       acomp_use_ref,
  input  wire logic       wdt_enable,
  input  wire logic       ext_irq_two,
  input  wire logic       ext_irq_one_level,
  input  wire logic       ext_irq_zero_level,
  input  wire logic       ext_irq_edge,
  input  wire logic       twi_addr_match,
  input  wire logic       timer2_irq,
  input  wire logic       spm_ee_ready,
  input  wire logic       adc_done,
  input  wire logic       other_io_irq,
  input  wire logic       tap_shift,
  input  wire logic       tap_tdo_data,
  output logic            cpu_clk_en,
  output logic            flash_clk_en,
  output logic            io_clk_en,
  output logic            adc_clk_en,
  output logic            asy_clk_en,
  output logic            main_osc_en,
  output logic            timer_osc_en,
  output logic            sleeping,
  output logic [2:0]      sleep_mode,
  output logic            adc_power,
  output logic            adc_ext_conv,
  output logic            acomp_power,
  output logic            vref_power,
  output logic            vref_ready,
  output logic            bod_power,
  output logic            wdt_run,
  output logic            input_buf_en,
  output logic            scan_if_en,
  output logic            tdo_out,
  output logic            tdo_oe
);
  import slp_pkg::*;

  localparam int CW = `SLP_CNT_W;

  if (OSC_WAKE_CYC < 1 || OSC_WAKE_CYC >= 2**CW ||
      VREF_CYC < 1 || VREF_CYC >= 2**CW) begin : g_chk
    $error("slp_ctrl: delay counts out of range");
  end

  slp_state_t     st;
  slp_state_t     next_st;
  logic           wake_load;
  logic [CW-1:0]  wake_val;
  logic           wake_done;
  logic           vref_load;
  logic           vref_done;
  logic           wake_hit;
  logic           dbg_osc;
  logic           deep;
  logic [2:0]     eff_mode;
  logic           mode_legal;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // clocks and oscillators left running in a given sleep mode
  function automatic slp_clk_t clk_cfg(input logic [2:0] m,
                                       input logic async,
                                       input logic dbg);
    slp_clk_t c;
    c = '0;
    case (m)
      `SLP_MODE_IDLE: begin
        c.io       = 1'b1;
        c.adc      = 1'b1;
        c.asy      = 1'b1;
        c.main_osc = 1'b1;
        c.tmr_osc  = async;
      end
      `SLP_MODE_ADCNR: begin
        c.adc      = 1'b1;
        c.asy      = 1'b1;
        c.main_osc = 1'b1;
        c.tmr_osc  = async;
      end
      `SLP_MODE_PDOWN: begin
        c.main_osc = dbg;
      end
      `SLP_MODE_PSAVE: begin
        c.asy      = async;
        c.tmr_osc  = async;
        c.main_osc = dbg;
      end
      `SLP_MODE_STBY: begin
        c.main_osc = 1'b1;
      end
      `SLP_MODE_XSTBY: begin
        c.asy      = async;
        c.tmr_osc  = async;
        c.main_osc = 1'b1;
      end
      default: begin
        c = '1;
        c.tmr_osc = async;
      end
    endcase
    return c;
  endfunction

  // true when a mode has io and adc clocks stopped
  function automatic logic is_deep(input logic [2:0] m);
    return !(m == `SLP_MODE_IDLE || m == `SLP_MODE_ADCNR);
  endfunction

  // ---------------------------------------------------------------
  // mode decode and wake-up qualification
  // ---------------------------------------------------------------

  // standby modes fall back to their oscillator-off twins without ext crystal
  always_comb begin
    eff_mode   = sleep_mode_select;
    mode_legal = 1'b1;
    case (sleep_mode_select)
      `SLP_MODE_STBY: begin
        if (!ext_crystal_sel) begin
          eff_mode = `SLP_MODE_PDOWN;
        end
      end
      `SLP_MODE_XSTBY: begin
        if (!ext_crystal_sel) begin
          eff_mode = `SLP_MODE_PSAVE;
        end
      end
      3'h4, 3'h5: begin
        mode_legal = 1'b0; // reserved codes: no sleep
      end
      default: begin
        mode_legal = 1'b1;
      end
    endcase
  end

  // wake sources that count in the current sleep mode
  always_comb begin
    logic ext;
    ext = ext_irq_two | ext_irq_one_level | ext_irq_zero_level;
    case (st.mode)
      `SLP_MODE_IDLE: begin
        wake_hit = ext | ext_irq_edge | twi_addr_match | timer2_irq |
                   spm_ee_ready | adc_done | other_io_irq;
      end
      `SLP_MODE_ADCNR: begin
        wake_hit = ext | twi_addr_match | timer2_irq |
                   spm_ee_ready | adc_done;
      end
      `SLP_MODE_PSAVE, `SLP_MODE_XSTBY: begin
        wake_hit = ext | twi_addr_match |
                   (timer2_irq & timer2_async_select);
      end
      default: begin
        wake_hit = ext | twi_addr_match;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------

  // sequencing, clock gating and analog power control
  always_comb begin
    next_st   = st;
    wake_load = 1'b0;
    wake_val  = '0;
    next_st.scan_if_en = scan_port_enable_fuse &
                         !scan_port_disable;
    dbg_osc = debug_enable_fuse & next_st.scan_if_en;
    case (st.fsm)
      ST_ACTIVE: begin
        if (sleep_req && mode_legal) begin
          next_st.fsm  = ST_SLEEP;
          next_st.mode = eff_mode;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          next_st.fsm = ST_WAKE;
          wake_load   = 1'b1;
          if (st.mode == `SLP_MODE_STBY ||
              st.mode == `SLP_MODE_XSTBY) begin
            wake_val = CW'(`SLP_STBY_WAKE_CYC - 1);
          end else if (!is_deep(st.mode)) begin
            wake_val = CW'(`SLP_FAST_WAKE_CYC - 1);
          end else begin
            wake_val = CW'(OSC_WAKE_CYC - 1);
          end
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          next_st.fsm = ST_ACTIVE;
        end
      end
      default: begin
        next_st.fsm = ST_ACTIVE;
      end
    endcase

    // clocks restart in wake, cpu and flash only once it ends
    case (next_st.fsm)
      ST_SLEEP: begin
        next_st.clk = clk_cfg(next_st.mode, timer2_async_select,
                              dbg_osc);
      end
      ST_WAKE: begin
        next_st.clk       = clk_cfg(3'h4, timer2_async_select,
                                    dbg_osc);
        next_st.clk.cpu   = 1'b0;
        next_st.clk.flash = 1'b0;
      end
      default: begin
        next_st.clk = clk_cfg(3'h4, timer2_async_select, dbg_osc);
      end
    endcase
    next_st.sleeping = (next_st.fsm != ST_ACTIVE);
    deep = (next_st.fsm == ST_SLEEP) && is_deep(next_st.mode);

    next_st.adc_power   = adc_enable;
    next_st.acomp_power = acomp_enable & !deep;
    next_st.bod_power   = brownout_enable_fuse;
    next_st.wdt_run     = wdt_enable;
    next_st.vref_power  = brownout_enable_fuse | adc_enable |
                          (acomp_enable & acomp_use_ref);
    vref_load = next_st.vref_power & !st.vref_power;
    next_st.vref_ready = next_st.vref_power & st.vref_power &
                         vref_done;

    next_st.input_buf_en = next_st.clk.io |
                           next_st.clk.adc;

    next_st.tdo_oe  = next_st.scan_if_en & tap_shift;
    next_st.tdo_out = tap_tdo_data & next_st.tdo_oe;

    // a fresh enable beats a start in the same cycle
    next_st.adc_en_d = adc_enable;
    if (adc_conv_start) begin
      next_st.adc_ext_conv = 1'b0;
    end
    if (adc_enable && !st.adc_en_d) begin
      next_st.adc_ext_conv = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register and delay counters
  // ---------------------------------------------------------------

  // register the whole state; clk_en freezes it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st              <= '0;
      st.fsm          <= ST_ACTIVE;
      st.clk          <= 7'h7E;
      st.input_buf_en <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  slp_cnt #(.W(CW)) u_wake_cnt (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .load     (wake_load),
    .load_val (wake_val),
    .done     (wake_done)
  );

  slp_cnt #(.W(CW)) u_vref_cnt (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .load     (vref_load),
    .load_val (CW'(VREF_CYC - 1)),
    .done     (vref_done)
  );

  // outputs straight from the state register
  assign cpu_clk_en   = st.clk.cpu;
  assign flash_clk_en = st.clk.flash;
  assign io_clk_en    = st.clk.io;
  assign adc_clk_en   = st.clk.adc;
  assign asy_clk_en   = st.clk.asy;
  assign main_osc_en  = st.clk.main_osc;
  assign timer_osc_en = st.clk.tmr_osc;
  assign sleeping     = st.sleeping;
  assign sleep_mode   = st.mode;
  assign adc_power    = st.adc_power;
  assign adc_ext_conv = st.adc_ext_conv;
  assign acomp_power  = st.acomp_power;
  assign vref_power   = st.vref_power;
  assign vref_ready   = st.vref_ready;
  assign bod_power    = st.bod_power;
  assign wdt_run      = st.wdt_run;
  assign input_buf_en = st.input_buf_en;
  assign scan_if_en   = st.scan_if_en;
  assign tdo_out      = st.tdo_out;
  assign tdo_oe       = st.tdo_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_idle_clocks: assert property (
    st.fsm == ST_SLEEP && st.mode == `SLP_MODE_IDLE |->
      !st.clk.cpu && !st.clk.flash && st.clk.io && st.clk.adc &&
      st.clk.asy && st.clk.main_osc)
    else $error("idle clock set wrong");
  a_adcnr_clocks: assert property (
    st.fsm == ST_SLEEP && st.mode == `SLP_MODE_ADCNR |->
      !st.clk.io && !st.clk.cpu && st.clk.adc && st.clk.main_osc)
    else $error("adc noise clock set wrong");
  a_async_timer: assert property (
    clk_en && next_st.fsm == ST_SLEEP &&
    next_st.mode == `SLP_MODE_PSAVE |=>
      st.clk.asy == $past(timer2_async_select))
    else $error("async clock not tied to select");
  a_stby_osc: assert property (
    st.fsm == ST_SLEEP && st.mode[2:1] == 2'h3 |-> st.clk.main_osc)
    else $error("standby oscillator stopped");
  a_pdown_wake: assert property (
    clk_en && st.fsm == ST_SLEEP && st.mode == `SLP_MODE_PDOWN &&
    !ext_irq_two && !ext_irq_one_level && !ext_irq_zero_level &&
    !twi_addr_match |=> st.fsm == ST_SLEEP)
    else $error("power-down woke on wrong source");
  a_ext_conv: assert property (
    clk_en && adc_enable && !st.adc_en_d |=> st.adc_ext_conv)
    else $error("extended conversion not flagged");
  a_acomp_off: assert property (
    st.fsm == ST_SLEEP && is_deep(st.mode) |-> !st.acomp_power)
    else $error("comparator on in deep sleep");
  a_vref_need: assert property (
    clk_en && !brownout_enable_fuse && !adc_enable &&
    !(acomp_enable && acomp_use_ref) |=> !st.vref_power && !st.vref_ready)
    else $error("reference on without user");
  a_inbuf_off: assert property (
    !st.clk.io && !st.clk.adc |-> !st.input_buf_en)
    else $error("input buffers left on");
  a_tdo_float: assert property (
    st.tdo_oe |-> st.scan_if_en)
    else $error("tdo driven while scan port off");
  a_stby_wake: assert property (
    @(posedge clk_sys) disable iff (!rstn || !clk_en)
    st.fsm == ST_SLEEP && st.mode == `SLP_MODE_STBY &&
    next_st.fsm == ST_WAKE |=>
      (!st.clk.cpu)[*6] ##1 st.clk.cpu)
    else $error("standby wake not six cycles");
  a_cpu_last: assert property (
    $rose(st.clk.cpu) && $past(rstn) |->
      $past(st.clk.io) && $past(st.clk.main_osc))
    else $error("cpu clock before domains");

  c_idle_trip: cover property (
    st.fsm == ST_SLEEP && st.mode == `SLP_MODE_IDLE ##1
    st.fsm == ST_WAKE);
  c_stby_trip: cover property (
    st.fsm == ST_WAKE && st.mode == `SLP_MODE_STBY ##[1:8]
    st.fsm == ST_ACTIVE);
  c_vref_up: cover property ($rose(st.vref_ready));
endmodule
`default_nettype wire

// *** dv/test_sleep_mode_clock_gating.sv ***
// self-checking testbench of the sleep-mode clock gating controller
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_clock_gating;
  import slp_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int OSC_W  = 2;
  localparam int VREF_W = 3;
  logic       clk_sys = 1'h0;
  logic       rstn    = 1'h0;
  logic       clk_en  = 1'h1;
  logic       sleep_req = 1'h0;
  logic [2:0] mode    = 3'h0;
  logic       xtal = 1'h1, asel = 1'h0, bodf = 1'h0, dbgf = 1'h0;
  logic       scanf = 1'h0, scand = 1'h0, adce = 1'h0, convs = 1'h0;
  logic       acme = 1'h0, aref = 1'h0, wdte = 1'h0, tsh = 1'h0;
  logic       tdat = 1'h0;
  logic [8:0] wk = 9'h000;
  logic       cpu, flash, io, adc, asy, mosc, tosc, slp;
  logic [2:0] smode;
  logic       adcp, extc, acp, vrp, vrr, bodp, wdtr, ibuf, scen;
  logic       tdo, tdoe;
  logic [6:0] clkv;
  int         miscompares = 0;
  int         n_tests     = 0;
  int         cyc         = 0;

  assign clkv = {cpu, flash, io, adc, asy, mosc, tosc};

  // ---------------------------------------------------------------
  // clock, design and watchdog on the run length
  // ---------------------------------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  slp_ctrl #(.OSC_WAKE_CYC(OSC_W), .VREF_CYC(VREF_W)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .sleep_req(sleep_req), .sleep_mode_select(mode),
    .ext_crystal_sel(xtal), .timer2_async_select(asel),
    .brownout_enable_fuse(bodf), .debug_enable_fuse(dbgf),
    .scan_port_enable_fuse(scanf), .scan_port_disable(scand),
    .adc_enable(adce), .adc_conv_start(convs), .acomp_enable(acme),
    .acomp_use_ref(aref), .wdt_enable(wdte), .ext_irq_two(wk[0]),
    .ext_irq_one_level(wk[1]), .ext_irq_zero_level(wk[2]),
    .ext_irq_edge(wk[3]), .twi_addr_match(wk[4]), .timer2_irq(wk[5]),
    .spm_ee_ready(wk[6]), .adc_done(wk[7]), .other_io_irq(wk[8]),
    .tap_shift(tsh), .tap_tdo_data(tdat), .cpu_clk_en(cpu),
    .flash_clk_en(flash), .io_clk_en(io), .adc_clk_en(adc),
    .asy_clk_en(asy), .main_osc_en(mosc), .timer_osc_en(tosc),
    .sleeping(slp), .sleep_mode(smode), .adc_power(adcp),
    .adc_ext_conv(extc), .acomp_power(acp), .vref_power(vrp),
    .vref_ready(vrr), .bod_power(bodp), .wdt_run(wdtr),
    .input_buf_en(ibuf), .scan_if_en(scen), .tdo_out(tdo),
    .tdo_oe(tdoe)
  );

  // a hang counts as a mismatch and closes the run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // reference model and compares
  // ---------------------------------------------------------------
  // expected {cpu,flash,io,adc,asy,main,tosc} while asleep
  function automatic logic [6:0] exp_clk(input logic [2:0] m,
                                         input logic a, input logic dg);
    case (m)
      3'h0:    exp_clk = {6'h0F, a};
      3'h1:    exp_clk = {6'h07, a};
      3'h2:    exp_clk = {5'h00, dg, 1'h0};
      3'h3:    exp_clk = {4'h0, a, dg, a};
      3'h6:    exp_clk = 7'h02;
      default: exp_clk = {4'h0, a, 1'h1, a};
    endcase
  endfunction

  // wake sources honoured per mode, bit order as wk
  function automatic logic [8:0] allow(input logic [2:0] m, input logic a);
    case (m)
      3'h0:       allow = 9'h1FF;
      3'h1:       allow = 9'h0F7;
      3'h2, 3'h6: allow = 9'h017;
      default:    allow = {3'h0, a, 5'h17};
    endcase
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_clk(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int         b;
    int         d;
    logic [2:0] eff;
    logic [6:0] ev;
    logic [8:0] am;
    logic       dg;
    void'($urandom(13));
    repeat (4) @(negedge clk_sys);
    chk_clk(clkv, 7'h7E);
    chk_bit(ibuf, 1'h1);
    chk_bit(slp, 1'h0);
    rstn = 1'h1;
    // reserved codes must not start a sleep
    for (int c = 4; c < 6; c++) begin
      @(negedge clk_sys);
      mode = c[2:0];
      sleep_req = 1'h1;
      @(negedge clk_sys);
      sleep_req = 1'h0;
      chk_bit(slp, 1'h0);
      chk_bit(cpu, 1'h1);
    end
    // reference start-up and extended conversion after re-enable
    adce = 1'h1;
    @(negedge clk_sys);
    chk_bit(vrp, 1'h1);
    for (int k = 1; k <= VREF_W; k++) begin
      @(negedge clk_sys);
      chk_bit(vrr, k == VREF_W);
    end
    chk_bit(extc, 1'h1);
    convs = 1'h1;
    @(negedge clk_sys);
    convs = 1'h0;
    adce = 1'h0;
    chk_bit(extc, 1'h0);
    @(negedge clk_sys);
    chk_bit(vrp, 1'h0);
    adce = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk_bit(extc, 1'h1);
    // tdo drive only while the port is enabled and shifting
    scanf = 1'h1;
    tsh = 1'h1;
    tdat = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk_bit(tdoe, 1'h1);
    chk_bit(tdo, 1'h1);
    tsh = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk_bit(tdoe, 1'h0);
    tsh = 1'h1;
    scand = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk_bit(scen, 1'h0);
    chk_bit(tdoe, 1'h0);
    // every mode with random configuration and wake sources
    for (int i = 0; i < 24; i++) begin
      case (i % 6)
        0: mode = 3'h0;
        1: mode = 3'h1;
        2: mode = 3'h2;
        3: mode = 3'h3;
        4: mode = 3'h6;
        default: mode = 3'h7;
      endcase
      xtal = ($urandom_range(3) != 0);
      {asel, bodf, dbgf, scanf, scand} = 5'($urandom_range(31));
      {adce, acme, aref, wdte, tsh, tdat} = 6'($urandom_range(63));
      eff = mode;
      if (!xtal && mode[2]) eff = {1'h0, mode[1:0]};
      dg = scanf & ~scand & dbgf;
      d = (eff < 2) ? 1 : (eff >= 6) ? 6 : OSC_W;
      ev = exp_clk(eff, asel, dg);
      am = allow(eff, asel);
      repeat (2) @(negedge clk_sys);
      sleep_req = 1'h1;
      @(negedge clk_sys);
      sleep_req = 1'h0;
      chk_clk(clkv, ev);
      chk_bit(slp, 1'h1);
      chk_mode(smode, eff);
      if (am != 9'h1FF) begin
        do b = $urandom_range(8); while (am[b]);
        wk = 9'h001 << b;
      end
      repeat (2) @(negedge clk_sys);
      chk_clk(clkv, ev);
      chk_bit(slp, 1'h1);
      chk_bit(acp, acme & (eff < 2));
      chk_bit(adcp, adce);
      chk_bit(bodp, bodf);
      chk_bit(wdtr, wdte);
      chk_bit(ibuf, ev[4] | ev[3]);
      chk_bit(scen, scanf & ~scand);
      do b = $urandom_range(8); while (!am[b]);
      wk = 9'h001 << b;
      for (int k = 0; k <= d; k++) begin
        @(negedge clk_sys);
        chk_bit(cpu, k == d);
        chk_bit(slp, k < d);
        if (k == 0) chk_bit(io, 1'h1);
      end
      wk = 9'h000;
    end
    // clk_en low freezes a power-down sleep, then a mid-run reset
    mode = 3'h2;
    sleep_req = 1'h1;
    @(negedge clk_sys);
    sleep_req = 1'h0;
    clk_en = 1'h0;
    wk = 9'h001;
    repeat (2) @(negedge clk_sys);
    chk_bit(slp, 1'h1);
    chk_clk(clkv, exp_clk(3'h2, asel, dg));
    clk_en = 1'h1;
    wk = 9'h000;
    rstn = 1'h0;
    @(negedge clk_sys);
    rstn = 1'h1;
    chk_clk(clkv, 7'h7E);
    chk_bit(slp, 1'h0);
    @(negedge clk_sys);
    report_and_stop();
  end
endmodule
`default_nettype wire
